// ==== core/bcte_encoder.sv ====
/*
 * Bus cycle type encoder: registers the cycle-kind code, access-class flag
 * and active-low write/read line for each bus cycle.
 * Assumes the bus controller presents a target class, region and attributes
 * on i_clk with a one-cycle start strobe; all inputs but the asynchronous i_reset_n are synchronous.
 * Outputs stand between starts; show-cycle scheduling lies elsewhere.
 */
`timescale 1ns/1ps
// Functional notes
// - Ordinary external bus cycle drives cycle kind 0000.
// - Data access code 0001 means external access starting a reservation.
// - Instruction access code 0001 means external indirect flow target.
// - Emulation memory replacing on-chip memory gives code 0010.
// - Port replacement chip cycle gives code 0011.
// - On-chip instruction-side memory access gives code 0100.
// - On-chip load/store-side memory access gives code 0101.
// - Cache hit outside chip-select regions gives code 0110.
// - On-chip register access gives code 0111.
// - Cache hits in boot region give 1000, regions one to five 1001-1101.
// - Write/read low on such fetches exactly when indirect change-of-flow.
// - Access-class flag tells instruction from data.
module bcte_encoder (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Cycle description from the bus controller
    input wire logic i_cycle_start,
    input wire bcte_pkg::bcte_target_e i_target,
    input wire logic i_cache_in_region,
    input wire logic [bcte_pkg::REGION_W-1:0] i_region,
    input wire logic i_is_insn,
    input wire logic i_indirect_flow,
    input wire logic i_write,
    // Show cycle pins
    output logic [bcte_pkg::KIND_W-1:0] o_cycle_kind_code,
    output logic o_access_class_flag,
    output logic o_write_read_n
);
    import bcte_pkg::*;

    // ************************************************************
    // Code selection
    // ************************************************************
    logic [KIND_W-1:0] next_kind;
    logic [KIND_W-1:0] region_kind;
    logic [REGION_W-1:0] region_clip;
    logic fetch_marked;
    logic next_wr_n;

    // Out-of-range regions clip to region five so no reserved code escapes.
    // A wrong region is easier to trace than an illegal code would be.
    assign region_clip = (i_region > REGION_MAX) ? REGION_MAX
                                                 : i_region;
    assign region_kind = KIND_HIT_BOOT + {1'b0, region_clip};

    always_comb begin
        next_kind = KIND_NORMAL;
        unique case (i_target)
            BCTE_TGT_EXT: next_kind = KIND_NORMAL;
            BCTE_TGT_EXT_RESV: next_kind = KIND_RESV_ICOF;
            BCTE_TGT_EXT_ICOF: next_kind = KIND_RESV_ICOF;
            BCTE_TGT_EMUL: next_kind = KIND_EMUL_MEM;
            BCTE_TGT_PORT_REPL: next_kind = KIND_PORT_REPL;
            BCTE_TGT_IBUS: next_kind = KIND_IBUS_MEM;
            BCTE_TGT_LBUS: next_kind = KIND_LBUS_MEM;
            BCTE_TGT_CACHE: next_kind = i_cache_in_region ? region_kind
                                                          : KIND_HIT_NOCS;
            BCTE_TGT_REG: next_kind = KIND_INT_REG;
            default: next_kind = KIND_NORMAL;
        endcase
    end

    // Reservation cycles are data and flow targets are instructions.
    logic next_class;
    assign next_class = (i_target == BCTE_TGT_EXT_RESV) ? ACCESS_DATA :
                        (i_target == BCTE_TGT_EXT_ICOF) ? ACCESS_INSN :
                        i_is_insn;

    assign fetch_marked = (next_class == ACCESS_INSN) &&
        (i_target inside {BCTE_TGT_EMUL, BCTE_TGT_IBUS, BCTE_TGT_LBUS,
                          BCTE_TGT_CACHE});
    // Fetches are reads, so the line is free to carry the flow mark there.
    assign next_wr_n = fetch_marked ? ~i_indirect_flow : ~i_write;

    // ************************************************************
    // Output registers
    // ************************************************************
    // Outputs hold between starts so capture hardware may sample them
    // late in a show cycle without racing the next description.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cycle_kind_code <= KIND_RESET;
            o_access_class_flag <= ACCESS_DATA;
            o_write_read_n <= WR_N_RESET;
        end else if (i_cycle_start) begin
            o_cycle_kind_code <= next_kind;
            o_access_class_flag <= next_class;
            o_write_read_n <= next_wr_n;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    // Each code check but chk_no_reserved looks one clock after the start that carries it,
    // since every output comes from a flip-flop loaded by that start.
    chk_no_reserved: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        o_cycle_kind_code <= KIND_HIT_LAST)
        else $error("reserved cycle kind driven");
    chk_ext_normal: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_cycle_start && i_target == BCTE_TGT_EXT |=>
        o_cycle_kind_code == 4'h0)
        else $error("normal cycle not coded 0000");
    chk_resv_data: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_cycle_start && i_target == BCTE_TGT_EXT_RESV |=>
        o_cycle_kind_code == 4'h1 && !o_access_class_flag)
        else $error("reservation not coded 0001 data");
    chk_icof_insn: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_cycle_start && i_target == BCTE_TGT_EXT_ICOF |=>
        o_cycle_kind_code == 4'h1 && o_access_class_flag)
        else $error("flow target not coded 0001 insn");
    chk_emul_code: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_cycle_start && i_target == BCTE_TGT_EMUL |=>
        o_cycle_kind_code == 4'h2)
        else $error("emulation memory not coded 0010");
    chk_port_code: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_cycle_start && i_target == BCTE_TGT_PORT_REPL |=>
        o_cycle_kind_code == 4'h3)
        else $error("port replacement not coded 0011");
    chk_ibus_code: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_cycle_start && i_target == BCTE_TGT_IBUS |=>
        o_cycle_kind_code == 4'h4)
        else $error("instruction memory not coded 0100");
    chk_lbus_code: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_cycle_start && i_target == BCTE_TGT_LBUS |=>
        o_cycle_kind_code == 4'h5)
        else $error("load store memory not coded 0101");
    chk_hit_nocs: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_cycle_start && i_target == BCTE_TGT_CACHE && !i_cache_in_region
        |=> o_cycle_kind_code == 4'h6)
        else $error("plain cache hit not coded 0110");
    chk_reg_code: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_cycle_start && i_target == BCTE_TGT_REG |=>
        o_cycle_kind_code == 4'h7)
        else $error("register access not coded 0111");
    chk_region_code: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_cycle_start && i_target == BCTE_TGT_CACHE && i_cache_in_region &&
        i_region <= 3'h5 |=>
        o_cycle_kind_code == 4'h8 + {1'b0, $past(i_region)})
        else $error("region cache hit code wrong");
    // An index past region five is a bus controller fault; the code then
    // saturates at region five instead of reaching a reserved value.
    chk_region_clip: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_cycle_start && i_target == BCTE_TGT_CACHE && i_cache_in_region &&
        i_region > 3'h5 |=> o_cycle_kind_code == 4'hd)
        else $error("out of range region not saturated");

    // ************************************************************
    // Write/read and class checks
    // ************************************************************
    // The write/read line carries the flow mark only on instruction fetches
    // that are shown from memory or cache; elsewhere it tells write from read.
    chk_flow_mark: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_cycle_start && i_is_insn && i_target == BCTE_TGT_IBUS |=>
        o_write_read_n == !$past(i_indirect_flow))
        else $error("flow mark not on write read line");
    chk_flow_other: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_cycle_start && i_is_insn &&
        i_target inside {BCTE_TGT_EMUL, BCTE_TGT_LBUS, BCTE_TGT_CACHE} |=>
        o_write_read_n == !$past(i_indirect_flow))
        else $error("flow mark wrong on other marked fetch");
    chk_write_plain: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_cycle_start && !(i_is_insn && i_target inside {BCTE_TGT_EMUL,
        BCTE_TGT_IBUS, BCTE_TGT_LBUS, BCTE_TGT_CACHE}) |=>
        o_write_read_n == !$past(i_write))
        else $error("write read line not following write");
    chk_class_follow: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_cycle_start &&
        !(i_target inside {BCTE_TGT_EXT_RESV, BCTE_TGT_EXT_ICOF}) |=>
        o_access_class_flag == $past(i_is_insn))
        else $error("access class not following transfer");
    chk_hold: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        !i_cycle_start |=> $stable(o_cycle_kind_code) &&
        $stable(o_access_class_flag))
        else $error("outputs changed without a cycle");
    chk_hold_wr: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        !i_cycle_start |=> $stable(o_write_read_n))
        else $error("write read line changed without a cycle");

    // ************************************************************
    // Cover points
    // ************************************************************
    // These mark the main show-cycle kinds that a run should reach.
    cov_region_five: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        o_cycle_kind_code == 4'hd);
    cov_marked_fetch: cover property (@(posedge i_clk)
        disable iff (!i_reset_n)
        o_access_class_flag && !o_write_read_n &&
        o_cycle_kind_code == 4'h4);
    cov_resv_then_reg: cover property (@(posedge i_clk)
        disable iff (!i_reset_n)
        o_cycle_kind_code == 4'h1 ##1 o_cycle_kind_code == 4'h7);
    cov_port_repl: cover property (@(posedge i_clk)
        disable iff (!i_reset_n)
        o_cycle_kind_code == 4'h3);
    cov_data_write: cover property (@(posedge i_clk)
        disable iff (!i_reset_n)
        !o_access_class_flag && !o_write_read_n);
endmodule // bcte_encoder

// ==== core/bcte_pkg.sv ====
/*
 * Package for the bus cycle type encoder: cycle-kind codes and widths.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package bcte_pkg;
    localparam int KIND_W = 4;
    localparam int REGION_W = 3;
    localparam logic [3:0] KIND_NORMAL = 4'h0;
    localparam logic [3:0] KIND_RESV_ICOF = 4'h1;
    localparam logic [3:0] KIND_EMUL_MEM = 4'h2;
    localparam logic [3:0] KIND_PORT_REPL = 4'h3;
    localparam logic [3:0] KIND_IBUS_MEM = 4'h4;
    localparam logic [3:0] KIND_LBUS_MEM = 4'h5;
    localparam logic [3:0] KIND_HIT_NOCS = 4'h6;
    localparam logic [3:0] KIND_INT_REG = 4'h7;
    localparam logic [3:0] KIND_HIT_BOOT = 4'h8;
    localparam logic [3:0] KIND_HIT_LAST = 4'hd;
    localparam logic [2:0] REGION_MAX = 3'h5;
    localparam logic [3:0] KIND_RESET = 4'h0;
    localparam logic WR_N_RESET = 1'b1;
    localparam logic ACCESS_DATA = 1'b0;
    localparam logic ACCESS_INSN = 1'b1;

    typedef enum logic [3:0] {
        BCTE_TGT_EXT,
        BCTE_TGT_EXT_RESV,
        BCTE_TGT_EXT_ICOF,
        BCTE_TGT_EMUL,
        BCTE_TGT_PORT_REPL,
        BCTE_TGT_IBUS,
        BCTE_TGT_LBUS,
        BCTE_TGT_CACHE,
        BCTE_TGT_REG
    } bcte_target_e;
endpackage

// ==== test/bcte_capture.sv ====
/* Capture model of trace hardware decoding the show cycle kind code.
   Assumes it watches the encoder's pins in the encoder's clock domain. */
`timescale 1ns/1ps
module bcte_capture (
    // Show cycle pins
    input wire logic [bcte_pkg::KIND_W-1:0] i_code,
    // Decoded view
    output logic o_internal,
    output logic o_invalid
);
    import bcte_pkg::*;
    // Reserved codes are flagged, never decoded as a target.
    assign o_invalid = (i_code > KIND_HIT_LAST);
    assign o_internal = (i_code > KIND_PORT_REPL) && !o_invalid;
endmodule // bcte_capture

// ==== test/testbench.sv ====
/* Self-checking bench for the bus cycle type encoder.
   Assumes the encoder answers one clock after an accepted start. */
`timescale 1ns/1ps
module testbench;
    import bcte_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_cycle_start = 1'b0;
    bcte_target_e i_target = BCTE_TGT_EXT;
    logic i_cache_in_region = 1'b0;
    logic [2:0] i_region = 3'h0;
    logic i_is_insn = 1'b0;
    logic i_indirect_flow = 1'b0;
    logic i_write = 1'b0;
    logic [3:0] o_cycle_kind_code;
    logic o_access_class_flag;
    logic o_write_read_n;
    logic cap_internal;
    logic cap_invalid;
    logic [3:0] want [9] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
        4'h6, 4'h7};
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    always #50 i_clk = ~i_clk;
    bcte_encoder uut (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_cycle_start(i_cycle_start), .i_target(i_target),
        .i_cache_in_region(i_cache_in_region), .i_region(i_region),
        .i_is_insn(i_is_insn), .i_indirect_flow(i_indirect_flow),
        .i_write(i_write), .o_cycle_kind_code(o_cycle_kind_code),
        .o_access_class_flag(o_access_class_flag),
        .o_write_read_n(o_write_read_n));
    bcte_capture cap (.i_code(o_cycle_kind_code),
        .o_internal(cap_internal), .o_invalid(cap_invalid));
    // ********************
    // Tasks
    // ********************
    task automatic print_verdict();
        if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic compare(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic send(input bcte_target_e t, input logic r,
        input logic [2:0] rg, input logic ins, ind, wr);
        @(posedge i_clk);
        i_cycle_start <= 1'b1;
        i_target <= t;
        i_cache_in_region <= r;
        i_region <= rg;
        i_is_insn <= ins;
        i_indirect_flow <= ind;
        i_write <= wr;
        @(posedge i_clk);
        i_cycle_start <= 1'b0;
        #1;
    endtask
    task automatic check_reset();
        compare(o_cycle_kind_code, 4'h0);
        compare({3'h0, o_access_class_flag}, 4'h0);
        compare({3'h0, o_write_read_n}, 4'h1);
    endtask
    task automatic t_kinds();
        logic mk;
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 9; i++) begin
                send(bcte_target_e'(i), 1'b0, 3'h0, k != 0, k == 1,
                    k != 1);
                mk = (k != 0) && (i == 3 || i == 5 || i == 6 || i == 7);
                compare(o_cycle_kind_code,
                    want[i]);
                compare({3'h0, o_access_class_flag},
                    {3'h0, (i == 2) || (k != 0 && i != 1)});
                compare({3'h0, o_write_read_n},
                    {3'h0, mk ? k != 1 : k == 1});
                compare({3'h0, cap_internal}, {3'h0, i > 4});
            end
        end
    endtask
    task automatic t_regions();
        for (int r = 0; r < 8; r++) begin
            send(BCTE_TGT_CACHE, 1'b1, r[2:0], 1'b1, 1'b1, 1'b0);
            compare(o_cycle_kind_code,
                4'h8 + ((r > 5) ? 4'h5 : r[3:0]));
            compare({3'h0, cap_invalid}, 4'h0);
            compare({3'h0, cap_internal}, 4'h1);
            compare({3'h0, o_write_read_n}, 4'h0);
        end
    endtask
    task automatic t_hold();
        send(BCTE_TGT_REG, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1);
        @(posedge i_clk);
        i_target <= BCTE_TGT_IBUS;
        i_is_insn <= 1'b1;
        i_indirect_flow <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1;
        compare(o_cycle_kind_code, 4'h7);
        compare({3'h0, o_access_class_flag}, 4'h0);
        compare({3'h0, o_write_read_n}, 4'h0);
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        #60;
        check_reset();
        @(posedge i_clk);
        i_reset_n <= 1'b1;
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 1000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (7) @(posedge i_clk);
        #1;
        check_reset();
        @(posedge i_clk);
        i_reset_n <= 1'b1;
        t_kinds();
        t_regions();
        t_hold();
        t_regions();
        print_verdict();
    end
endmodule // testbench
